// ### ssla_pkg.sv
// constants and types of the synchronous serial line adapter
`default_nettype none
package ssla_pkg;
   // clock and loopback test bit time
   localparam int CLK_NS = 8;
   localparam int TEST_BIT_NS = 64;
   localparam int TEST_BIT_CYC = (TEST_BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] TEST_DIV_LAST = 4'(TEST_BIT_CYC - 1);
   // line register numbers
   localparam logic [2:0] REG_DATA = 3'h1;
   localparam logic [2:0] REG_CONTROL = 3'h2;
   localparam logic [2:0] REG_FILL = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;
   localparam logic [2:0] REG_CONFIG = 3'h6;
   // field positions; documented bit 0 is the vector msb
   localparam int CTL_DSC_HI = 7;
   localparam int CTL_DSC_LO = 4;
   localparam int CTL_CLKSEL = 3;
   localparam int CTL_LOOP = 2;
   localparam int CTL_RXON = 1;
   localparam int CTL_TXON = 0;
   localparam int PKG_CTS = 2;
   localparam int ST_READY = 3;
   localparam int ST_TXNE = 2;
   localparam int ST_OVR = 1;
   localparam int ST_UNR = 0;
   localparam int CFG_SIZE_HI = 7;
   localparam int CFG_SIZE_LO = 6;
   // character size codes
   localparam logic [1:0] SIZE5 = 2'h0;
   localparam logic [1:0] SIZE6 = 2'h2;
   localparam logic [1:0] SIZE7 = 2'h1;
   localparam logic [1:0] SIZE8 = 2'h3;
   // reset values
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] FILL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // fifo shape
   localparam int FIFO_DEPTH = 128;
   localparam logic [7:0] FIFO_FULL = 8'h80;

   typedef struct packed {
      logic write;
      logic channel;
      logic adapter;
      logic [2:0] regSel;
      logic [7:0] data;
   } ssla_cmd_t;

   typedef enum logic [3:0] {
      RX_OFF = 4'h1,
      RX_HUNT = 4'h2,
      RX_SECOND = 4'h4,
      RX_DATA = 4'h8
   } ssla_rx_state_t;
endpackage
`default_nettype wire

// ### ssla_adapter.sv
// synchronous serial line adapter: registers, fifos, serializer
// Behaviour
// - receive fifo 128x8, read pops oldest once
// - first received bit lands lsb, right-justified
// - one control register for both channels
// - control bits 0-3 go to package control
// - control bit 4 goes to package clock
// - loopback: test clock, cts forced, tx to rx
// - receiver-on enables receive and its requests
// - transmitter-on enables requests while space free
// - shared fill/sync pattern, lsb first
// - empty fifo sends fill, sets underrun
// - status read copies package status bits
// - tx requests need cts and transmitter-on
// - ready: tx not full, rx not empty
// - tx-not-empty drops once fifo drained with transmitter-on off
// - overrun set when received characters lost
// - size code selects 5,6,7,8 bits
// - one size register for both directions
// - processor fills tx fifo, line drains oldest
// - transmit lsb first, only configured bits
// - adapter control sets loop, rx-on, tx-on
// - rx-on rise restarts sync, two matches needed
// - overrun clears on next receive data read
`timescale 1ns/1ps
`default_nettype none
module ssla_adapter
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic cmdValid,
   input wire ssla_pkg::ssla_cmd_t cmd,
   output logic rspValid,
   output logic [7:0] rspData,
   output logic rxRequest,
   output logic txRequest,
   output logic [3:0] packageControlReg,
   output logic packageClockSel,
   input wire logic [3:0] packageStatusReg,
   input wire logic lineClk,
   input wire logic lineRxData,
   output logic lineTxData
);
   logic [7:0] control;
   logic [7:0] fill;
   logic [7:0] charCfg;
   logic [3:0] pkgMeta;
   logic [3:0] pkgSync;
   logic [2:0] clkSync;
   logic [1:0] rxdSync;
   logic [3:0] testDiv;
   logic testTick;
   logic loopback;
   logic rcvOn;
   logic xmitOn;
   logic rcvOnPrev;
   logic xmitOnPrev;
   logic rcvRise;
   logic ctsEff;
   logic rxTick;
   logic txTick;
   logic rxBit;
   logic [3:0] charLen;
   logic [7:0] charMask;
   logic [3:0] alignShift;
   logic [7:0] rxMem [0:ssla_pkg::FIFO_DEPTH-1];
   logic [7:0] txMem [0:ssla_pkg::FIFO_DEPTH-1];
   logic [6:0] rxWr;
   logic [6:0] rxRd;
   logic [7:0] rxCount;
   logic [6:0] txWr;
   logic [6:0] txRd;
   logic [7:0] txCount;
   logic rxEmpty;
   logic rxFull;
   logic txEmpty;
   logic txFull;
   logic rxPop;
   logic rxPush;
   logic txPush;
   logic txPop;
   logic statusRead;
   ssla_pkg::ssla_rx_state_t rxState;
   logic [7:0] rxWin;
   logic [7:0] next_rxWin;
   logic [7:0] rxAligned;
   logic rxMatch;
   logic [3:0] rxCnt;
   logic [3:0] next_rxCnt;
   logic rxOverrun;
   logic [7:0] txShift;
   logic [3:0] txCnt;
   logic txRunning;
   logic txBoundary;
   logic txNotEmpty;
   logic txUnderrun;
   logic [7:0] genStatus;

   assign loopback = control[ssla_pkg::CTL_LOOP];
   assign rcvOn = control[ssla_pkg::CTL_RXON];
   assign xmitOn = control[ssla_pkg::CTL_TXON];
   assign rcvRise = rcvOn & ~rcvOnPrev;

   // processor register port
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         control <= ssla_pkg::CTL_RESET;
         fill <= ssla_pkg::FILL_RESET;
         charCfg <= ssla_pkg::CFG_RESET;
      end
      else if (cmdValid && cmd.write)
      begin
         if (cmd.adapter)
            control[ssla_pkg::CTL_LOOP:ssla_pkg::CTL_TXON] <=
               cmd.data[ssla_pkg::CTL_LOOP:ssla_pkg::CTL_TXON];
         else if (cmd.regSel == ssla_pkg::REG_CONTROL)
            control <= cmd.data;
         else if (cmd.regSel == ssla_pkg::REG_FILL)
            fill <= cmd.data;
         else if (cmd.regSel == ssla_pkg::REG_CONFIG)
            charCfg <= cmd.data;
      end
   end

   // package outputs change only on a control write, not via adapter op
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         packageControlReg <= 4'h0;
         packageClockSel <= 1'b0;
      end
      else if (cmdValid && cmd.write && !cmd.adapter &&
               cmd.regSel == ssla_pkg::REG_CONTROL)
      begin
         packageControlReg <=
            cmd.data[ssla_pkg::CTL_DSC_HI:ssla_pkg::CTL_DSC_LO];
         packageClockSel <= cmd.data[ssla_pkg::CTL_CLKSEL];
      end
   end

   // pin synchronisers
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pkgMeta <= 4'h0;
         pkgSync <= 4'h0;
         clkSync <= 3'h0;
         rxdSync <= 2'h3;
      end
      else
      begin
         pkgMeta <= packageStatusReg;
         pkgSync <= pkgMeta;
         clkSync <= {clkSync[1:0], lineClk};
         rxdSync <= {rxdSync[0], lineRxData};
      end
   end

   // test clock divider, one bit per tick
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         testDiv <= 4'h0;
      else if (!loopback || testDiv == ssla_pkg::TEST_DIV_LAST)
         testDiv <= 4'h0;
      else
         testDiv <= testDiv + 4'h1;
   end
   assign testTick = loopback && testDiv == ssla_pkg::TEST_DIV_LAST;

   // loopback swaps clock, cts and receive data source
   assign ctsEff = loopback | pkgSync[ssla_pkg::PKG_CTS];
   assign rxTick = loopback ? testTick : (clkSync[1] & ~clkSync[2]);
   assign txTick = loopback ? testTick : (~clkSync[1] & clkSync[2]);
   assign rxBit = loopback ? lineTxData : rxdSync[1];

   // character size; parity is just another data bit here
   always_comb
   begin
      unique case (charCfg[ssla_pkg::CFG_SIZE_HI:ssla_pkg::CFG_SIZE_LO])
         ssla_pkg::SIZE5: charLen = 4'h5;
         ssla_pkg::SIZE6: charLen = 4'h6;
         ssla_pkg::SIZE7: charLen = 4'h7;
         ssla_pkg::SIZE8: charLen = 4'h8;
      endcase
   end
   assign alignShift = 4'h8 - charLen;
   assign charMask = 8'hff >> alignShift;

   // fifo flags and transfers
   assign rxEmpty = rxCount == 8'h00;
   assign rxFull = rxCount == ssla_pkg::FIFO_FULL;
   assign txEmpty = txCount == 8'h00;
   assign txFull = txCount == ssla_pkg::FIFO_FULL;
   assign rxPop = cmdValid && !cmd.write && !cmd.adapter && !cmd.channel &&
                  cmd.regSel == ssla_pkg::REG_DATA && !rxEmpty;
   assign txPush = cmdValid && cmd.write && !cmd.adapter && cmd.channel &&
                   cmd.regSel == ssla_pkg::REG_DATA && !txFull;
   assign statusRead = cmdValid && !cmd.write &&
                       (cmd.adapter || cmd.regSel == ssla_pkg::REG_STATUS);
   assign rxRequest = rcvOn & ~rxEmpty;
   assign txRequest = xmitOn & ctsEff & ~txFull;

   // receive fifo; restart of sync flushes it
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rxWr <= 7'h00;
         rxRd <= 7'h00;
         rxCount <= 8'h00;
      end
      else if (rcvRise)
      begin
         rxWr <= 7'h00;
         rxRd <= 7'h00;
         rxCount <= 8'h00;
      end
      else
      begin
         if (rxPush && !rxFull)
            rxWr <= rxWr + 7'h01;
         if (rxPop)
            rxRd <= rxRd + 7'h01;
         if (rxPush && !rxFull && !rxPop)
            rxCount <= rxCount + 8'h01;
         else if (rxPop && !(rxPush && !rxFull))
            rxCount <= rxCount - 8'h01;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rxPush && !rxFull)
         rxMem[rxWr] <= rxAligned;
      if (txPush)
         txMem[txWr] <= cmd.data;
   end

   // transmit fifo
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txWr <= 7'h00;
         txRd <= 7'h00;
         txCount <= 8'h00;
      end
      else
      begin
         if (txPush)
            txWr <= txWr + 7'h01;
         if (txPop)
            txRd <= txRd + 7'h01;
         if (txPush && !txPop)
            txCount <= txCount + 8'h01;
         else if (txPop && !txPush)
            txCount <= txCount - 8'h01;
      end
   end

   // receiver: window shifts right, newest bit enters at the top
   assign next_rxWin = {rxBit, rxWin[7:1]};
   assign rxAligned = (next_rxWin >> alignShift) & charMask;
   assign rxMatch = rxAligned == (fill & charMask);
   assign next_rxCnt = rxCnt + 4'h1;
   assign rxPush = rxTick && rcvOn && !rcvRise &&
                   rxState == ssla_pkg::RX_DATA &&
                   next_rxCnt == charLen;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rxState <= ssla_pkg::RX_OFF;
         rxWin <= 8'h00;
         rxCnt <= 4'h0;
         rcvOnPrev <= 1'b0;
      end
      else
      begin
         rcvOnPrev <= rcvOn;
         if (!rcvOn)
            rxState <= ssla_pkg::RX_OFF;
         else if (rcvRise)
         begin
            rxState <= ssla_pkg::RX_HUNT;
            rxCnt <= 4'h0;
            // stale bits from an earlier session must not fake a match
            rxWin <= 8'h00;
         end
         else if (rxTick)
         begin
            rxWin <= next_rxWin;
            unique case (rxState)
               ssla_pkg::RX_OFF:
                  rxState <= ssla_pkg::RX_OFF;
               ssla_pkg::RX_HUNT:
               begin
                  rxCnt <= 4'h0;
                  if (rxMatch)
                     rxState <= ssla_pkg::RX_SECOND;
               end
               ssla_pkg::RX_SECOND:
               begin
                  rxCnt <= next_rxCnt;
                  if (next_rxCnt == charLen)
                  begin
                     rxCnt <= 4'h0;
                     rxState <= rxMatch ? ssla_pkg::RX_DATA
                                        : ssla_pkg::RX_HUNT;
                  end
               end
               ssla_pkg::RX_DATA:
                  rxCnt <= (next_rxCnt == charLen) ? 4'h0 : next_rxCnt;
            endcase
         end
      end
   end

   // overrun: a loss in the same cycle as a pop still sets the flag
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rxOverrun <= 1'b0;
      else if (rxPush && rxFull)
         rxOverrun <= 1'b1;
      else if (rxPop)
         rxOverrun <= 1'b0;
   end

   // transmitter; the count-zero tick loads the next character, no gap between characters
   assign txBoundary = txTick && ctsEff && txCnt == 4'h0;
   assign txPop = txBoundary && !txEmpty && (txRunning || xmitOn);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txShift <= 8'h00;
         txCnt <= 4'h0;
         txRunning <= 1'b0;
         lineTxData <= 1'b1;
      end
      else if (txTick && ctsEff)
      begin
         if (txCnt != 4'h0)
         begin
            lineTxData <= txShift[0];
            txShift <= txShift >> 1;
            txCnt <= txCnt - 4'h1;
         end
         else if (txPop)
         begin
            lineTxData <= txMem[txRd][0];
            txShift <= txMem[txRd] >> 1;
            txCnt <= charLen - 4'h1;
            txRunning <= 1'b1;
         end
         else if (xmitOn)
         begin
            lineTxData <= fill[0];
            txShift <= fill >> 1;
            txCnt <= charLen - 4'h1;
            txRunning <= 1'b1;
         end
         else
         begin
            lineTxData <= 1'b1;
            txRunning <= 1'b0;
         end
      end
   end

   // underrun clears on a status read; a new underrun wins
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         txUnderrun <= 1'b0;
      else if (txBoundary && txEmpty && xmitOn)
         txUnderrun <= 1'b1;
      else if (statusRead)
         txUnderrun <= 1'b0;
   end

   // tx-not-empty follows transmitter-on and the drain of the fifo
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txNotEmpty <= 1'b0;
         xmitOnPrev <= 1'b0;
      end
      else
      begin
         xmitOnPrev <= xmitOn;
         if (xmitOn && !xmitOnPrev)
            txNotEmpty <= 1'b1;
         else if (txBoundary && txEmpty && !xmitOn && txRunning)
            txNotEmpty <= 1'b0;
      end
   end

   // status word; ready bit depends on which channel asks
   always_comb
   begin
      genStatus = 8'h00;
      genStatus[ssla_pkg::ST_READY] = cmd.channel ? ~txFull
                                                  : ~rxEmpty;
      genStatus[ssla_pkg::ST_TXNE] = txNotEmpty;
      genStatus[ssla_pkg::ST_OVR] = rxOverrun;
      genStatus[ssla_pkg::ST_UNR] = txUnderrun;
   end

   // answers one cycle after a read; writes give no answer
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rspValid <= 1'b0;
         rspData <= 8'h00;
      end
      else
      begin
         rspValid <= cmdValid && !cmd.write;
         if (cmdValid && !cmd.write)
         begin
            if (cmd.adapter)
               rspData <= genStatus;
            else if (cmd.regSel == ssla_pkg::REG_STATUS)
               rspData <= {pkgSync, genStatus[3:0]};
            else if (rxPop)
               rspData <= rxMem[rxRd];
            else
               rspData <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ### ssla_adapter_sva.sv
// port checker of the synchronous serial line adapter
`timescale 1ns/1ps
`default_nettype none
module ssla_adapter_sva
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic cmdValid,
   input wire ssla_pkg::ssla_cmd_t cmd,
   input wire logic rspValid,
   input wire logic [7:0] rspData,
   input wire logic rxRequest,
   input wire logic txRequest,
   input wire logic [3:0] packageControlReg,
   input wire logic packageClockSel
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   logic [7:0] lastData;
   logic rd;
   logic adRd;
   logic stRd;
   logic ctlWr;
   logic onWr;
   // copy of the op data, so a forwarded field can be compared a cycle later
   always_ff @(posedge core_clk) lastData <= cmd.data;
   assign rd = cmdValid && !cmd.write;
   assign adRd = rd && cmd.adapter;
   assign stRd = rd && !cmd.adapter && cmd.regSel == ssla_pkg::REG_STATUS;
   assign ctlWr = cmdValid && cmd.write && !cmd.adapter
      && cmd.regSel == ssla_pkg::REG_CONTROL;
   assign onWr = ctlWr || (cmdValid && cmd.write && cmd.adapter);
   read_answer_a:
      assert property (rd |=> rspValid) else $error("read not answered");
   lone_answer_a:
      assert property (rspValid |-> $past(rd)) else $error("stray answer");
   data_hold_a:
      assert property (!rspValid |-> $stable(rspData))
         else $error("answer data moved");
   pkg_ctl_a:
      assert property (ctlWr |=> packageControlReg == lastData[7:4])
         else $error("control bits not forwarded");
   pkg_clk_a:
      assert property (ctlWr |=> packageClockSel == lastData[3])
         else $error("clock select not forwarded");
   pkg_hold_a:
      assert property (!ctlWr |=> $stable(packageControlReg)
         && $stable(packageClockSel)) else $error("package outputs moved");
   rx_off_a:
      assert property (onWr && !cmd.data[ssla_pkg::CTL_RXON] |=> !rxRequest)
         else $error("receive request while off");
   tx_off_a:
      assert property (onWr && !cmd.data[ssla_pkg::CTL_TXON] |=> !txRequest)
         else $error("transmit request while off");
   ad_status_a:
      assert property (adRd |=> rspData[7:4] == 4'h0)
         else $error("adapter status upper bits set");
   tx_ready_a:
      assert property (stRd && cmd.channel && txRequest |=> rspData[3])
         else $error("transmit ready bit low");
   rx_ready_a:
      assert property (stRd && !cmd.channel && rxRequest |=> rspData[3])
         else $error("receive ready bit low");
endmodule
bind ssla_adapter ssla_adapter_sva chk (.core_clk(core_clk), .nrst(nrst),
   .cmdValid(cmdValid), .cmd(cmd), .rspValid(rspValid), .rspData(rspData),
   .rxRequest(rxRequest), .txRequest(txRequest),
   .packageControlReg(packageControlReg), .packageClockSel(packageClockSel));
`default_nettype wire

// ### ssla_line_model.sv
// line side model: link clock and receive data
`timescale 1ns/1ps
`default_nettype none
module ssla_line_model
(
   input wire logic lineTxData,
   output logic lineClk,
   output logic lineRxData
);
   initial
   begin
      lineClk = 1'b0;
      lineRxData = 1'b1;
   end
   // clock stands still between frames, so the transmitter freezes there
   task automatic frame(input logic [31:0] bits, input int n);
      for (int i = 0; i < n; i++)
      begin
         lineRxData = bits[i];
         #32 lineClk = 1'b1;
         #32 lineClk = 1'b0;
      end
      lineRxData = ~lineRxData;
   endtask
endmodule
`default_nettype wire

// ### ssla_adapter_tb.sv
// testbench of the synchronous serial line adapter
`timescale 1ns/1ps
`default_nettype none
module ssla_adapter_tb;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic cmdValid = 1'b0;
   ssla_pkg::ssla_cmd_t cmd = '0;
   logic rspValid;
   logic [7:0] rspData;
   logic rxRequest;
   logic txRequest;
   logic [3:0] packageControlReg;
   logic packageClockSel;
   logic [3:0] packageStatusReg = 4'h0;
   logic lineClk;
   logic lineRxData;
   logic lineTxData;
   int error_cnt = 0;
   int n_tests = 0;
   int q[$];
   int r;
   logic [7:0] fill;
   logic [7:0] data;
   logic [7:0] mask;
   logic [1:0] codes [4] = '{ssla_pkg::SIZE5, ssla_pkg::SIZE6,
      ssla_pkg::SIZE7, ssla_pkg::SIZE8};
   always #4 core_clk = ~core_clk;
   ssla_adapter dut (.core_clk(core_clk), .nrst(nrst), .cmdValid(cmdValid),
      .cmd(cmd), .rspValid(rspValid), .rspData(rspData),
      .rxRequest(rxRequest), .txRequest(txRequest),
      .packageControlReg(packageControlReg),
      .packageClockSel(packageClockSel), .packageStatusReg(packageStatusReg),
      .lineClk(lineClk), .lineRxData(lineRxData), .lineTxData(lineTxData));
   ssla_line_model line (.lineTxData(lineTxData), .lineClk(lineClk),
      .lineRxData(lineRxData));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one op; a read answer is looked at in the cycle it stands
   task automatic op(input logic w, input logic ch, input logic ad,
      input logic [2:0] rs, input logic [7:0] d, input logic [7:0] e);
      @(negedge core_clk);
      cmdValid = 1'b1;
      cmd = '{w, ch, ad, rs, d};
      @(negedge core_clk);
      cmdValid = 1'b0;
      if (!w)
      begin
         chk({7'h0, rspValid}, 8'h01);
         chk(rspData, e);
      end
   endtask
   task automatic waitRx();
      int i = 0;
      while (rxRequest !== 1'b1 && i < 4000)
      begin
         @(negedge core_clk);
         i++;
      end
      if (i == 4000)
      begin
         error_cnt++;
         results();
      end
   endtask
   initial
   begin
      r = $urandom(32'h5e633d51);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      chk({rxRequest, txRequest, lineTxData, packageClockSel,
         packageControlReg}, 8'h20);
      op(0, 0, 0, ssla_pkg::REG_DATA, 8'h00, 8'h00);
      packageStatusReg = 4'($urandom) & 4'hb;
      repeat (4) @(negedge core_clk);
      op(0, 0, 0, ssla_pkg::REG_STATUS, 8'h00, {packageStatusReg, 4'h0});
      op(1, 0, 1, 3'h0, 8'h01, 8'h00);
      chk({7'h0, txRequest}, 8'h00);
      packageStatusReg[2] = 1'b1;
      repeat (4) @(negedge core_clk);
      chk({7'h0, txRequest}, 8'h01);
      op(1, 0, 1, 3'h0, 8'h00, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         mask = 8'hff >> (3 - c);
         fill = 8'h16 & mask;
         data = 8'($urandom) & mask;
         op(1, c[0], 0, ssla_pkg::REG_CONFIG, {codes[c], 6'h0}, 8'h0);
         op(1, 1, 0, ssla_pkg::REG_FILL, fill, 8'h00);
         op(1, 1, 0, ssla_pkg::REG_DATA, fill, 8'h00);
         op(1, 1, 0, ssla_pkg::REG_DATA, fill, 8'h00);
         op(1, 1, 0, ssla_pkg::REG_DATA, data, 8'h00);
         q = {data};
         while (q.size() < 128)
            q.push_back(fill);
         op(1, 0, 1, 3'h0, 8'h07, 8'h00);
         // long enough for more characters than the receive fifo holds
         repeat (140 * 8 * (5 + c)) @(negedge core_clk);
         op(1, 0, 1, 3'h0, 8'h04, 8'h00);
         repeat (100) @(negedge core_clk);
         op(0, 0, 0, ssla_pkg::REG_STATUS, 8'h00, {packageStatusReg, 4'hb});
         while (q.size() > 0)
            op(0, 0, 0, ssla_pkg::REG_DATA, 8'h00, q.pop_front());
         op(0, 1, 1, 3'h0, 8'h00, 8'h08);
         op(0, 0, 0, ssla_pkg::REG_DATA, 8'h00, 8'h00);
         op(1, 0, 1, 3'h0, 8'h00, 8'h00);
      end
      data = 8'($urandom);
      r = $urandom;
      op(1, r[0], 0, ssla_pkg::REG_CONTROL, {r[7:3], 3'h2}, 8'h00);
      chk({3'h0, packageControlReg, packageClockSel}, {3'h0, r[7:3]});
      line.frame({4'hf, data, fill, fill}, 28);
      waitRx();
      op(0, 0, 0, ssla_pkg::REG_DATA, 8'h00, data);
      results();
   end
endmodule
`default_nettype wire
